// *** rate_counter_observe_select_pkg.sv ***
// shared constants and carriers for the rate generator and diagnostic view
package rate_counter_observe_select_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_CONTROL = 14'h0F50;
  localparam logic [13:0] IDX_RATE_HIGH = 14'h0F53;
  localparam logic [13:0] IDX_RATE_LOW = 14'h0F54;
  localparam logic [13:0] IDX_COUNTER_OBSERVE_SELECT_STATE = 14'h0F55;
  localparam logic [13:0] IDX_COUNTER_OBSERVE_SELECT_CONTROL = 14'h0F56;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h0F57;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0F58;

  // ==========================================================
  // field positions
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_TIMER_IRQ_BIT = 4;
  localparam int COUNTER_OBSERVE_SELECT_OBSERVE_BIT = 0;
  localparam int EVT_TIMEOUT_BIT = 0;
  localparam int EVT_CLOCK_EDGE_BIT = 1;
  localparam int EVT_WIDTH = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] RATE_BYTE_RESET = 8'hFF;
  localparam logic [4:0] FSM_STATE_IDLE = 5'h00;
  localparam logic [4:0] FSM_STATE_START = 5'h01;
  localparam logic LINE_IDLE_LEVEL = 1'b1;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic clock_line_level;
    logic data_line_level;
    logic stop_count_flag;
    logic [4:0] protocol_fsm_state;
  } counter_observe_select_view_t;

  typedef struct packed {
    logic controller_on_bit;
    logic timer_irq_enable;
  } ctrl_t;

endpackage : rate_counter_observe_select_pkg

// *** line_sync.sv ***
// three-stage synchroniser with agreement filter for one bus line
`timescale 1ns/10ps
`default_nettype none
module line_sync
  import rate_counter_observe_select_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // asynchronous line and filtered level
  input wire logic line_in,
  output logic level_out
);

  logic meta_r;
  logic stage2_r;
  logic stage3_r;

  // ==========================================================
  // chain; the first stage feeds only the second
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      meta_r <= LINE_IDLE_LEVEL;
      stage2_r <= LINE_IDLE_LEVEL;
      stage3_r <= LINE_IDLE_LEVEL;
    end else begin
      meta_r <= line_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

  // ==========================================================
  // a change counts only once two stages agree
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      level_out <= LINE_IDLE_LEVEL;
    end else if (stage2_r == stage3_r) begin
      level_out <= stage3_r;
    end
  end

endmodule : line_sync
`default_nettype wire

// *** rate_counter_observe_select_top.sv ***
// two-wire controller rate generator, timer, and diagnostic view
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module rate_counter_observe_select_top
  import rate_counter_observe_select_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // bus lines, asynchronous
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  // from the byte transfer engine, same clock
  input wire logic stop_count_in,
  input wire logic [4:0] fsm_state_in,
  // to the byte transfer engine and the system
  output logic rate_tick_out,
  output logic controller_on_out,
  output logic irq_out
);

  ctrl_t ctrl_r;
  logic [7:0] rate_reload_upper_r;
  logic [7:0] rate_reload_lower_r;
  logic counter_observe_select_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] rate_reload_value;
  logic [EVT_WIDTH-1:0] status_r;
  logic [EVT_WIDTH-1:0] mask_r;
  logic [EVT_WIDTH-1:0] event_set;
  logic [4:0] fsm_state_r;
  logic stop_count_r;
  logic clock_level;
  logic data_level;
  logic clock_prev_r;
  counter_observe_select_view_t counter_observe_select_view;
  logic timeout;
  logic timer_evt;
  logic access;
  logic wr_commit;
  logic rd_take;
  logic [13:0] index;
  logic mapped;
  logic [7:0] wbyte;

  // ==========================================================
  // line sampling
  line_sync u_scl_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .line_in(scl_line_in),
    .level_out(clock_level)
  );

  line_sync u_sda_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .line_in(sda_line_in),
    .level_out(data_level)
  );

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clock_prev_r <= LINE_IDLE_LEVEL;
    end else begin
      clock_prev_r <= clock_level;
    end
  end

  // ==========================================================
  // apb decode; one wait state so every answer comes from a flop
  assign access = psel_in && penable_in;
  assign wr_commit = access && pready_out && pwrite_in;
  assign rd_take = access && !pready_out;
  assign index = paddr_in[15:2];
  assign wbyte = pwdata_in[7:0];

  always_comb begin
    unique case (index)
      IDX_CONTROL, IDX_RATE_HIGH, IDX_RATE_LOW, IDX_COUNTER_OBSERVE_SELECT_STATE,
      IDX_COUNTER_OBSERVE_SELECT_CONTROL, IDX_IRQ_STATUS, IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= access && !pready_out;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pslverr_out <= 1'b0;
    end else if (rd_take) begin
      pslverr_out <= !mapped;
    end else if (pready_out) begin
      pslverr_out <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_r <= '0;
    end else if (wr_commit && index == IDX_CONTROL) begin
      ctrl_r.controller_on_bit <= wbyte[CTRL_ON_BIT];
      ctrl_r.timer_irq_enable <= wbyte[CTRL_TIMER_IRQ_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      counter_observe_select_r <= 1'b0;
    end else if (wr_commit && index == IDX_COUNTER_OBSERVE_SELECT_CONTROL) begin
      counter_observe_select_r <= wbyte[COUNTER_OBSERVE_SELECT_OBSERVE_BIT];
    end
  end

  // ==========================================================
  // rate bytes
  // high byte, all ones
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rate_reload_upper_r <= RATE_BYTE_RESET;
    end else if (wr_commit && index == IDX_RATE_HIGH) begin
      rate_reload_upper_r <= wbyte;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rate_reload_lower_r <= RATE_BYTE_RESET;
    end else if (wr_commit && index == IDX_RATE_LOW) begin
      rate_reload_lower_r <= wbyte;
    end
  end

  assign rate_reload_value = {rate_reload_upper_r, rate_reload_lower_r};

  // ==========================================================
  // rate counter; a new reload takes effect at the next time-out,
  // so a time-out between the two byte writes loads a half-old period
  assign timeout = (count_r <= COUNT_ONE);

  always_comb begin
    if (timeout) begin
      count_nxt = rate_reload_value;
    end else begin
      count_nxt = count_r - COUNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_r <= {RATE_BYTE_RESET, RATE_BYTE_RESET};
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rate_tick_out <= 1'b0;
    end else begin
      rate_tick_out <= timeout;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      controller_on_out <= 1'b0;
    end else begin
      controller_on_out <= ctrl_r.controller_on_bit;
    end
  end

  assign timer_evt = timeout && !ctrl_r.controller_on_bit && ctrl_r.timer_irq_enable;

  // ==========================================================
  // interrupt status, mask and output; a set beats a clear
  assign event_set[EVT_TIMEOUT_BIT] = timer_evt;
  assign event_set[EVT_CLOCK_EDGE_BIT] = clock_prev_r && !clock_level;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_WIDTH; gi++) begin : g_status
      always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
          status_r[gi] <= 1'b0;
        end else if (event_set[gi]) begin
          status_r[gi] <= 1'b1;
        end else if (wr_commit && index == IDX_IRQ_STATUS && wbyte[gi]) begin
          status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mask_r <= '0;
    end else if (wr_commit && index == IDX_IRQ_MASK) begin
      mask_r <= wbyte[EVT_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_r & mask_r);
    end
  end

  // ==========================================================
  // diagnostic view
  // state resets to zero
  // idle and start codes pass through
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      fsm_state_r <= FSM_STATE_IDLE;
      stop_count_r <= 1'b0;
    end else begin
      fsm_state_r <= fsm_state_in;
      stop_count_r <= stop_count_in;
    end
  end

  assign counter_observe_select_view.clock_line_level = clock_level;
  assign counter_observe_select_view.data_line_level = data_level;
  assign counter_observe_select_view.stop_count_flag = stop_count_r;
  assign counter_observe_select_view.protocol_fsm_state = fsm_state_r;

  // ==========================================================
  // read data, captured in the first access cycle
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      prdata_out <= '0;
    end else if (rd_take) begin
      prdata_out <= '0;
      unique case (index)
        IDX_CONTROL: begin
          prdata_out[CTRL_ON_BIT] <= ctrl_r.controller_on_bit;
          prdata_out[CTRL_TIMER_IRQ_BIT] <= ctrl_r.timer_irq_enable;
        end
        IDX_RATE_HIGH: begin
          prdata_out[7:0] <= counter_observe_select_r ? count_r[15:8] : rate_reload_upper_r;
        end
        IDX_RATE_LOW: begin
          prdata_out[7:0] <= counter_observe_select_r ? count_r[7:0] : rate_reload_lower_r;
        end
        IDX_COUNTER_OBSERVE_SELECT_STATE: begin
          prdata_out[7:0] <= counter_observe_select_view;
        end
        IDX_COUNTER_OBSERVE_SELECT_CONTROL: begin
          prdata_out[COUNTER_OBSERVE_SELECT_OBSERVE_BIT] <= counter_observe_select_r;
        end
        IDX_IRQ_STATUS: begin
          prdata_out[EVT_WIDTH-1:0] <= status_r;
        end
        IDX_IRQ_MASK: begin
          prdata_out[EVT_WIDTH-1:0] <= mask_r;
        end
        default: begin
          prdata_out <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  a_count_reload: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (timeout && !wr_commit) |=> (count_r == $past(rate_reload_value)))
    else $error("counter did not reload at time-out");
  // the release edge still loads the reset count, so it is not a count-down step
  a_count_down: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (!reset_in && !timeout) |=> (count_r == $past(count_r) - COUNT_ONE))
    else $error("counter did not count down by one");
  a_timer_sets: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (timeout && ctrl_r.timer_irq_enable && !ctrl_r.controller_on_bit) |=> status_r[EVT_TIMEOUT_BIT])
    else $error("timer time-out did not set status");
  a_on_blocks_timer: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (ctrl_r.controller_on_bit && !status_r[EVT_TIMEOUT_BIT]) |=> !status_r[EVT_TIMEOUT_BIT])
    else $error("timer status set while controller on");
  a_irq_level: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    ##1 (irq_out == |($past(status_r) & $past(mask_r))))
    else $error("interrupt output disagrees with masked status");
  a_observe_high: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (rd_take && index == IDX_RATE_HIGH && counter_observe_select_r)
    |=> (prdata_out[7:0] == $past(count_r[15:8])))
    else $error("high byte read did not return counter");
  a_observe_low: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (rd_take && index == IDX_RATE_LOW && counter_observe_select_r)
    |=> (prdata_out[7:0] == $past(count_r[7:0])))
    else $error("low byte read did not return counter");
  a_counter_observe_select_read: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (rd_take && index == IDX_COUNTER_OBSERVE_SELECT_STATE)
    |=> (prdata_out[7:0] == {$past(clock_level), $past(data_level), $past(stop_count_r),
        $past(fsm_state_r)}))
    else $error("diagnostic read mismatch");
  a_counter_observe_select_ro: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (wr_commit && index == IDX_COUNTER_OBSERVE_SELECT_STATE)
    |=> ($stable(rate_reload_value) && $stable(ctrl_r) && $stable(mask_r)))
    else $error("write to diagnostic register changed state");
  a_reset_ones: assert property (
    @(posedge sys_clk_in)
    reset_in |=> (rate_reload_value == {RATE_BYTE_RESET, RATE_BYTE_RESET}
      && fsm_state_r == FSM_STATE_IDLE))
    else $error("reset values wrong");

endmodule : rate_counter_observe_select_top
`default_nettype wire

// *** line_partner.sv ***
// two-wire bus partner model driving the clock and data lines
`timescale 1ns/10ps
`default_nettype none
module line_partner (
  // controls from the bench
  input wire logic run_in,
  input wire logic hold_low_in,
  // bus lines, pulled up when released
  output logic scl_out,
  output logic sda_out
);
  // ==========================================
  // link clock runs only within frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    #37;
    forever begin
      if (run_in) begin
        #160 scl_out = 1'b0;
        sda_out = ~sda_out;
        #160 scl_out = 1'b1;
      end else begin
        // held lines sit low, released lines float to the pull-up level
        scl_out = !hold_low_in;
        sda_out = !hold_low_in;
        #20;
      end
    end
  end
endmodule : line_partner
`default_nettype wire

// *** test_rate_counter_observe_select_top.sv ***
// self-checking bench for the rate generator and diagnostic view
`timescale 1ns/10ps
`default_nettype none
module test_rate_counter_observe_select_top;
  import rate_counter_observe_select_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, scl, sda, tick, con, irq, run = 1'b0, hold = 1'b0;
  logic stop_flag = 1'b0;
  logic [4:0] fsm = 5'h00;
  int mismatches = 0, check_count = 0, cyc = 0, n;
  always #20 clk = ~clk;
  rate_counter_observe_select_top i_rate_counter_observe_select_top (.sys_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .scl_line_in(scl),
    .sda_line_in(sda), .stop_count_in(stop_flag), .fsm_state_in(fsm),
    .rate_tick_out(tick), .controller_on_out(con), .irq_out(irq));
  line_partner i_line_partner (.run_in(run), .hold_low_in(hold), .scl_out(scl),
    .sda_out(sda));
  // ==========================================
  // common tasks
  task automatic stop_test;
    $display("compares %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) mismatches++;
  endtask : apb
  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 70000);
    if (n >= 70000) mismatches++;
  endtask : wait_tick
  // ==========================================
  // scenarios
  task automatic reset_values;
    apb(1'b0, IDX_RATE_HIGH, 32'h0);
    check(rd, 32'h0000_00FF); // reset high
    apb(1'b0, IDX_RATE_LOW, 32'h0);
    check(rd, 32'h0000_00FF); // reset low
    apb(1'b0, IDX_COUNTER_OBSERVE_SELECT_STATE, 32'h0);
    check(rd, 32'h0000_00C0); // idle reads both lines high, state zero
  endtask : reset_values
  task automatic reg_access;
    apb(1'b1, IDX_RATE_HIGH, 32'h0000_00A5);
    apb(1'b1, IDX_RATE_LOW, 32'h0000_003C);
    apb(1'b0, IDX_RATE_HIGH, 32'h0);
    check(rd, 32'h0000_00A5); // high byte rw
    apb(1'b0, IDX_RATE_LOW, 32'h0);
    check(rd, 32'h0000_003C); // low byte rw
    // counter is still near all ones here, unlike the stored A5
    apb(1'b1, IDX_COUNTER_OBSERVE_SELECT_CONTROL, 32'h0000_0001);
    apb(1'b0, IDX_RATE_HIGH, 32'h0);
    check(rd, 32'h0000_00FF); // counter not stored byte
    apb(1'b1, IDX_COUNTER_OBSERVE_SELECT_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_COUNTER_OBSERVE_SELECT_STATE, 32'h0000_00FF);
    apb(1'b0, IDX_COUNTER_OBSERVE_SELECT_STATE, 32'h0);
    check(rd, 32'h0000_00C0); // writes ignored
    apb(1'b0, 14'h0F5F, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001); // unmapped index errors
  endtask : reg_access
  task automatic timer_use;
    apb(1'b1, IDX_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_RATE_HIGH, 32'h0000_0000);
    apb(1'b1, IDX_RATE_LOW, 32'h0000_0005);
    apb(1'b1, IDX_CONTROL, 32'h0000_0010);
    wait_tick();
    wait_tick();
    check(n, 5); // interval is reload
    wait_tick();
    check(n, 5); // periodic reload
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h0000_0001); // timeout event
    check(irq, 1'b0); // masked interrupt stays low
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_0001);
    repeat (3) @(posedge clk);
    check(irq, 1'b1); // interrupt raised
    apb(1'b1, IDX_CONTROL, 32'h0000_0000);
    apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0001);
    repeat (20) @(posedge clk);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check({rd[30:0], irq}, 32'h0); // no event when disabled
    apb(1'b1, IDX_CONTROL, 32'h0000_0090);
    repeat (20) @(posedge clk);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check({rd[30:0], con}, 32'h1); // enable ignored while on
  endtask : timer_use
  task automatic observe_counter;
    logic [31:0] first_low;
    apb(1'b1, IDX_COUNTER_OBSERVE_SELECT_CONTROL, 32'h0000_0001);
    apb(1'b0, IDX_RATE_HIGH, 32'h0);
    check(rd, 32'h0); // counter high byte
    apb(1'b0, IDX_RATE_LOW, 32'h0);
    first_low = rd;
    check(rd >= 32'h1 && rd <= 32'h5, 1'b1); // counter low byte
    // reads land four cycles apart on a five-cycle count, so a live counter differs
    apb(1'b0, IDX_RATE_LOW, 32'h0);
    check(rd != first_low && rd <= 32'h5, 1'b1); // counter moves
    apb(1'b1, IDX_COUNTER_OBSERVE_SELECT_CONTROL, 32'h0000_0000);
    apb(1'b0, IDX_RATE_LOW, 32'h0);
    check(rd, 32'h0000_0005); // reload restored on view
  endtask : observe_counter
  task automatic counter_observe_select_lines;
    apb(1'b1, IDX_CONTROL, 32'h0000_0000);
    stop_flag <= 1'b1;
    fsm <= FSM_STATE_START;
    hold <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, IDX_COUNTER_OBSERVE_SELECT_STATE, 32'h0);
    check(rd, 32'h0000_0021); // start state
    hold <= 1'b0;
    fsm <= 5'h1A;
    stop_flag <= 1'b0;
    apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0003);
    run <= 1'b1;
    repeat (32) @(posedge clk);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, IDX_COUNTER_OBSERVE_SELECT_STATE, 32'h0);
    check(rd, 32'h0000_00DA); // state field follows
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check(rd[1], 1'b1); // clock line edge event
  endtask : counter_observe_select_lines
  // ==========================================
  // hang guard and main sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    reg_access();
    timer_use();
    observe_counter();
    counter_observe_select_lines();
    stop_test();
  end
endmodule : test_rate_counter_observe_select_top
`default_nettype wire
